//--- hdl/pbc_control_reg.sv
`timescale 1ns/10ps
`default_nettype none

module pbc_control_reg
    import pbc_pkg::*;
(
    input  wire logic               CLK,
    input  wire logic               RST_N,
    input  wire logic               PD_STRAP,
    input  wire logic [4:0]         MGMT_ADDR,
    input  wire logic               MGMT_WR,
    input  wire logic               MGMT_RD,
    input  wire logic [15:0]        MGMT_WDATA,
    output logic      [15:0]        MGMT_RDATA,
    output logic                    MGMT_READY,
    input  wire logic               AUTONEG_ENABLE_CTL,
    input  wire logic               RESET_DONE,
    output logic                    VENDOR_SOFT_RESET_CTL,
    output logic                    PCS_LOOP_ENABLE_CTL,
    output logic                    VENDOR_POWER_DOWN_CTL,
    output logic                    MII_ISOLATION_CTL
);

    // reset synchroniser: assert at once, release through two flops
    logic                   rst_meta_reg;       // first stage, read only by second
    logic                   rst_sync_reg;       // released reset for the design
    logic                   rst_n_int;          // internal active-low reset

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    assign rst_n_int = rst_sync_reg;

    // strap pin synchroniser; the strap is an asynchronous pin level
    logic                   strap_meta_reg;     // first stage, read only by second
    logic                   strap_sync_reg;     // safe copy of the strap level

    always_ff @(posedge CLK or negedge rst_n_int) begin
        if (!rst_n_int) begin
            strap_meta_reg <= 1'b0;
            strap_sync_reg <= 1'b0;
        end else begin
            strap_meta_reg <= PD_STRAP;
            strap_sync_reg <= strap_meta_reg;
        end
    end

    // control state
    pbc_state_type          state_reg;          // sequencer state
    pbc_state_type          state_next;
    logic [1:0]             settle_reg;         // strap settle counter
    logic [1:0]             settle_next;
    logic                   loop_reg;           // local loopback field
    logic                   loop_next;
    logic                   pd_reg;             // software power-down field
    logic                   pd_next;
    logic                   iso_reg;            // mii isolate field
    logic                   iso_next;
    logic [15:0]            rdata_reg;          // registered read data
    logic [15:0]            rdata_next;
    logic                   wr_hit;             // write aimed at this register
    logic [15:0]            read_word;          // current register image

    assign wr_hit = MGMT_WR && (MGMT_ADDR == PBC_ADDR);

    // assemble the word seen by a read; fixed bits are constants
    always_comb begin
        read_word                 = 16'h0000;   // reserved bits 9 and 4:0 read 0
        read_word[SOFT_RESET_POS] = (state_reg == PBC_ST_SWRST);
        read_word[LOCAL_LOOP_POS] = loop_reg;
        read_word[SPEED_LOW_POS]  = SPEED_VALUE[0];
        read_word[AUTONEG_POS]    = AUTONEG_ENABLE_CTL;
        read_word[POWER_DOWN_POS] = pd_reg;
        read_word[ISOLATE_POS]    = iso_reg;
        read_word[DUPLEX_POS]     = DUPLEX_VALUE;
        read_word[COL_TEST_POS]   = COL_TEST_VALUE;
        read_word[SPEED_HIGH_POS] = SPEED_VALUE[1];
        read_word[ONE_WAY_POS]    = ONE_WAY_VALUE;
    end

    // next-state logic for the sequencer and writable fields
    always_comb begin
        state_next  = state_reg;
        settle_next = settle_reg;
        loop_next   = loop_reg;
        pd_next     = pd_reg;
        iso_next    = iso_reg;
        case (state_reg)
            PBC_ST_STRAP: begin
                // wait until the strap has crossed both flops
                if (settle_reg == STRAP_SETTLE) begin
                    pd_next    = strap_sync_reg;
                    state_next = PBC_ST_RUN;
                end else begin
                    settle_next = settle_reg + 2'h1;
                end
            end
            PBC_ST_RUN: begin
                // writes stay possible in power-down
                if (wr_hit) begin
                    loop_next = MGMT_WDATA[LOCAL_LOOP_POS];
                    pd_next   = MGMT_WDATA[POWER_DOWN_POS];
                    iso_next  = MGMT_WDATA[ISOLATE_POS];
                    if (MGMT_WDATA[SOFT_RESET_POS]) begin
                        state_next = PBC_ST_SWRST;
                    end
                end
            end
            PBC_ST_SWRST: begin
                // writes are dropped while the core resets; reads still work
                if (RESET_DONE) begin
                    loop_next  = LOCAL_LOOP_RST;
                    iso_next   = ISOLATE_RST;
                    pd_next    = strap_sync_reg;
                    state_next = PBC_ST_RUN;                       // self-clear
                end
            end
            default: begin
                state_next = PBC_ST_STRAP;
            end
        endcase
        // reads of unmapped addresses return zero
        if (MGMT_RD) begin
            rdata_next = (MGMT_ADDR == PBC_ADDR) ? read_word : 16'h0000;
        end else begin
            rdata_next = rdata_reg;
        end
    end

    // register the control state
    always_ff @(posedge CLK or negedge rst_n_int) begin
        if (!rst_n_int) begin
            state_reg  <= PBC_ST_STRAP;
            settle_reg <= 2'h0;
            loop_reg   <= LOCAL_LOOP_RST;
            pd_reg     <= PBC_RESET_VALUE[POWER_DOWN_POS];
            iso_reg    <= ISOLATE_RST;
            rdata_reg  <= 16'h0000;
        end else begin
            state_reg  <= state_next;
            settle_reg <= settle_next;
            loop_reg   <= loop_next;
            pd_reg     <= pd_next;
            iso_reg    <= iso_next;
            rdata_reg  <= rdata_next;
        end
    end

    // mirrored controls go straight from the fields; soft reset and ready decode the state
    assign MGMT_RDATA            = rdata_reg;
    assign MGMT_READY            = (state_reg != PBC_ST_STRAP);
    assign VENDOR_SOFT_RESET_CTL = (state_reg == PBC_ST_SWRST);
    assign PCS_LOOP_ENABLE_CTL   = loop_reg;
    assign VENDOR_POWER_DOWN_CTL = pd_reg;
    assign MII_ISOLATION_CTL     = iso_reg;

    // checks
    sequence s_reset_write;
        (state_reg == PBC_ST_RUN) && wr_hit && MGMT_WDATA[SOFT_RESET_POS];
    endsequence

    sequence s_reset_busy;
        VENDOR_SOFT_RESET_CTL && (state_reg == PBC_ST_SWRST);
    endsequence

    property p_swrst_start;
        @(posedge CLK) disable iff (!rst_n_int)
        s_reset_write |=> s_reset_busy;
    endproperty
    a_swrst_start: assert property (p_swrst_start) else $error("reset not started");

    property p_swrst_clear;
        @(posedge CLK) disable iff (!rst_n_int)
        (s_reset_busy and RESET_DONE) |=> !VENDOR_SOFT_RESET_CTL && !loop_reg && !iso_reg;
    endproperty
    a_swrst_clear: assert property (p_swrst_clear) else $error("reset not cleared");

    property p_loop_write;
        @(posedge CLK) disable iff (!rst_n_int)
        ((state_reg == PBC_ST_RUN) && wr_hit) |=>
            PCS_LOOP_ENABLE_CTL == $past(MGMT_WDATA[LOCAL_LOOP_POS]);
    endproperty
    a_loop_write: assert property (p_loop_write) else $error("loopback not written");

    property p_autoneg_read;
        @(posedge CLK) disable iff (!rst_n_int)
        (MGMT_RD && MGMT_ADDR == PBC_ADDR) |=>
            MGMT_RDATA[AUTONEG_POS] == $past(AUTONEG_ENABLE_CTL);
    endproperty
    a_autoneg_read: assert property (p_autoneg_read) else $error("autoneg bit wrong");

    property p_pd_write;
        @(posedge CLK) disable iff (!rst_n_int)
        ((state_reg == PBC_ST_RUN) && wr_hit) |=>
            VENDOR_POWER_DOWN_CTL == $past(MGMT_WDATA[POWER_DOWN_POS]);
    endproperty
    a_pd_write: assert property (p_pd_write) else $error("power-down not written");

    property p_strap_load;
        @(posedge CLK) disable iff (!rst_n_int)
        ((state_reg == PBC_ST_STRAP) && settle_reg == STRAP_SETTLE) |=>
            MGMT_READY && VENDOR_POWER_DOWN_CTL == $past(strap_sync_reg);
    endproperty
    a_strap_load: assert property (p_strap_load) else $error("strap not loaded");

    property p_iso_write;
        @(posedge CLK) disable iff (!rst_n_int)
        ((state_reg == PBC_ST_RUN) && wr_hit) |=>
            MII_ISOLATION_CTL == $past(MGMT_WDATA[ISOLATE_POS]);
    endproperty
    a_iso_write: assert property (p_iso_write) else $error("isolate not written");

    property p_fixed_bits;
        @(posedge CLK) disable iff (!rst_n_int)
        (MGMT_RD && MGMT_ADDR == PBC_ADDR) |=> MGMT_RDATA[DUPLEX_POS] && !MGMT_RDATA[COL_TEST_POS];
    endproperty
    a_fixed_bits: assert property (p_fixed_bits) else $error("duplex bit wrong");

    property p_col_test;
        @(posedge CLK) disable iff (!rst_n_int)
        (MGMT_RD && MGMT_ADDR == PBC_ADDR) |=> MGMT_RDATA[COL_TEST_POS] == 1'b0;
    endproperty
    a_col_test: assert property (p_col_test) else $error("collision bit set");

    property p_speed;
        @(posedge CLK) disable iff (!rst_n_int)
        (MGMT_RD && MGMT_ADDR == PBC_ADDR) |=>
            {MGMT_RDATA[SPEED_HIGH_POS], MGMT_RDATA[SPEED_LOW_POS]} == 2'b00;
    endproperty
    a_speed: assert property (p_speed) else $error("speed bits not 00");

    property p_one_way;
        @(posedge CLK) disable iff (!rst_n_int)
        (MGMT_RD && MGMT_ADDR == PBC_ADDR) |=>
            MGMT_RDATA[ONE_WAY_POS] == 1'b0 && MGMT_RDATA[4:0] == 5'h00;
    endproperty
    a_one_way: assert property (p_one_way) else $error("bit 5 or reserved set");

    property p_unmapped;
        @(posedge CLK) disable iff (!rst_n_int)
        (MGMT_RD && MGMT_ADDR != PBC_ADDR) |=> MGMT_RDATA == 16'h0000;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

    // a write in the busy window must stay out of the fields
    sequence s_busy_write;
        (state_reg == PBC_ST_SWRST) && wr_hit && !RESET_DONE;
    endsequence

    // the cycle in which the core reports the reset cycle over
    sequence s_reset_end;
        s_reset_busy ##0 RESET_DONE;
    endsequence

    property p_busy_write;
        @(posedge CLK) disable iff (!rst_n_int)
        s_busy_write |=> VENDOR_SOFT_RESET_CTL && $stable(loop_reg)
            && $stable(pd_reg) && $stable(iso_reg);
    endproperty
    a_busy_write: assert property (p_busy_write) else $error("busy write taken");

    // power-down comes back from the pin, not from the last write
    property p_pd_reload;
        @(posedge CLK) disable iff (!rst_n_int)
        s_reset_end |=> VENDOR_POWER_DOWN_CTL == $past(strap_sync_reg);
    endproperty
    a_pd_reload: assert property (p_pd_reload) else $error("strap not reloaded");

    // a write before the strap is caught must not land
    property p_early_wr;
        @(posedge CLK) disable iff (!rst_n_int)
        ((state_reg == PBC_ST_STRAP) && wr_hit) |=> $stable(loop_reg) && $stable(iso_reg);
    endproperty
    a_early_wr: assert property (p_early_wr) else $error("early write taken");

    // the busy flag reads back live while the core resets
    property p_busy_read;
        @(posedge CLK) disable iff (!rst_n_int)
        (MGMT_RD && MGMT_ADDR == PBC_ADDR) |=>
            MGMT_RDATA[SOFT_RESET_POS] == $past(VENDOR_SOFT_RESET_CTL);
    endproperty
    a_busy_read: assert property (p_busy_read) else $error("busy bit wrong");

    // stored fields read back in every mode, power-down included
    property p_fields_read;
        @(posedge CLK) disable iff (!rst_n_int)
        (MGMT_RD && MGMT_ADDR == PBC_ADDR) |=>
            MGMT_RDATA[LOCAL_LOOP_POS] == $past(PCS_LOOP_ENABLE_CTL)
            && MGMT_RDATA[POWER_DOWN_POS] == $past(VENDOR_POWER_DOWN_CTL)
            && MGMT_RDATA[ISOLATE_POS] == $past(MII_ISOLATION_CTL);
    endproperty
    a_fields_read: assert property (p_fields_read) else $error("field read wrong");

    // read data holds between reads so a slow host can pick it up
    property p_rdata_hold;
        @(posedge CLK) disable iff (!rst_n_int)
        !MGMT_RD |=> $stable(MGMT_RDATA);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");

endmodule : pbc_control_reg

`default_nettype wire

//--- hdl/pbc_pkg.sv
// Function
// - bit 15 write starts self-clearing soft reset
// - bit 14 engages PCS loopback, resets 0
// - bit 12 read-only, shows autoneg enable, resets 1
// - bit 11 powers down, management stays reachable
// - power-down reset value comes from strap pin
// - bit 10 isolates MII, resets 0, read/write
// - bit 8 ignores writes, reads 1
// - bit 7 ignores writes, reads 0
// - speed bits 6 and 13 read 00
// - bit 5 ignores writes, reads 0
// - register at address 0, resets 0x1100 with strap low, 0x1900 with strap high
package pbc_pkg;

    // management address space
    localparam int unsigned     ADDR_W           = 5;
    localparam int unsigned     DATA_W           = 16;
    localparam logic [4:0]      PBC_ADDR         = 5'h00;

    // bit positions inside the control word
    localparam int unsigned     SOFT_RESET_POS   = 15;
    localparam int unsigned     LOCAL_LOOP_POS   = 14;
    localparam int unsigned     SPEED_LOW_POS    = 13;
    localparam int unsigned     AUTONEG_POS      = 12;
    localparam int unsigned     POWER_DOWN_POS   = 11;
    localparam int unsigned     ISOLATE_POS      = 10;
    localparam int unsigned     DUPLEX_POS       = 8;
    localparam int unsigned     COL_TEST_POS     = 7;
    localparam int unsigned     SPEED_HIGH_POS   = 6;
    localparam int unsigned     ONE_WAY_POS      = 5;

    // reset and constant field values
    localparam logic [15:0]     PBC_RESET_VALUE  = 16'h1100;
    localparam logic            LOCAL_LOOP_RST   = 1'h0;
    localparam logic            ISOLATE_RST      = 1'h0;
    localparam logic            DUPLEX_VALUE     = 1'h1;
    localparam logic            COL_TEST_VALUE   = 1'h0;
    localparam logic [1:0]      SPEED_VALUE      = 2'h0;
    localparam logic            ONE_WAY_VALUE    = 1'h0;

    // cycles after reset release before the synchronised strap is valid
    localparam logic [1:0]      STRAP_SETTLE     = 2'h2;

    // control sequencer states
    typedef enum logic [1:0] {
        PBC_ST_STRAP = 2'b00,   // waiting to catch the power-down strap
        PBC_ST_RUN   = 2'b01,   // normal operation
        PBC_ST_SWRST = 2'b10    // software reset cycle in progress
    } pbc_state_type;

endpackage : pbc_pkg

//--- sim/pbc_core_model.sv
`timescale 1ns/10ps
`default_nettype none

// stand-in for the phy core: ends a soft reset cycle after a set delay
module pbc_core_model (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       soft_reset,
    input  wire logic [3:0] delay,
    output logic            reset_done
);
    logic [3:0] count_reg;  // cycles spent in the reset cycle

    // done is a single-cycle pulse, the least that a real core promises
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_reg  <= 4'h0;
            reset_done <= 1'b0;
        end else begin
            reset_done <= soft_reset && (count_reg == delay)
                          && !reset_done;
            count_reg  <= soft_reset ? count_reg + 4'h1 : 4'h0;
        end
    end
endmodule : pbc_core_model

`default_nettype wire

//--- sim/tb_phy_basic_control_register.sv
`timescale 1ns/10ps
`default_nettype none

module tb_phy_basic_control_register
    import pbc_pkg::*;
;
    logic        clk, rst_n, strap, wr, rd, an, done, srst, loop, pd, iso, ready;
    logic [4:0]  addr;    // management address
    logic [15:0] wdata;   // write word
    logic [15:0] rdata;   // read word
    logic [3:0]  dly;     // core model answer delay
    int          n_errors;
    int          n_checks;

    // free-running 50 MHz clock
    always #10 clk = ~clk;

    pbc_control_reg i_dut (.CLK(clk), .RST_N(rst_n), .PD_STRAP(strap), .MGMT_ADDR(addr),
        .MGMT_WR(wr), .MGMT_RD(rd), .MGMT_WDATA(wdata), .MGMT_RDATA(rdata),
        .MGMT_READY(ready), .AUTONEG_ENABLE_CTL(an), .RESET_DONE(done),
        .VENDOR_SOFT_RESET_CTL(srst), .PCS_LOOP_ENABLE_CTL(loop),
        .VENDOR_POWER_DOWN_CTL(pd), .MII_ISOLATION_CTL(iso));

    pbc_core_model i_core (.clk(clk), .rst_n(rst_n), .soft_reset(srst), .delay(dly),
        .reset_done(done));

    // single comparison point
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // one-cycle write strobe, taken at the second edge
    task automatic wr_word(input logic [4:0] a, input logic [15:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        @(negedge clk);
    endtask : wr_word

    // read strobe; data is settled by the following falling edge
    task automatic rd_word(input logic [4:0] a, input logic [15:0] exp);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        check(rdata, exp);
    endtask : rd_word

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : give_verdict

    // bounded wait on a flag reaching a level
    task automatic wait_for(input logic want, input bit use_ready);
        int i;
        for (i = 0; i < 40 && ((use_ready ? ready : srst) !== want); i++) @(negedge clk);
        if (i == 40) begin
            check({15'h0, (use_ready ? ready : srst)}, {15'h0, want});
            give_verdict();
        end
    endtask : wait_for

    // reset held ten cycles, then wait until writes are accepted
    task automatic reset_dut(input logic s);
        @(posedge clk);
        rst_n <= 1'b0;
        strap <= s;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        // a write before the strap is caught must be dropped
        repeat (2) @(posedge clk);
        wr_word(5'h00, 16'h4c00);
        wait_for(1'b1, 1'b1);
    endtask : reset_dut

    initial begin
        {clk, rst_n, strap, wr, rd, addr, wdata} = '0;
        an = 1'b1;
        dly = 4'h1;
        reset_dut(1'b0);
        rd_word(5'h00, PBC_RESET_VALUE);
        check({12'h0, srst, loop, pd, iso}, 16'h0000);
        $display("test reset value done");
        // every bit but 15 written as 1; read-only bits must not move
        @(posedge clk);
        an <= 1'b0;
        wr_word(5'h00, 16'h7fff);
        check({13'h0, loop, pd, iso}, 16'h0007);
        rd_word(5'h00, 16'h4d00);
        @(posedge clk);
        an <= 1'b1;
        $display("test writable bits done");
        // unmapped address: write dropped, read returns zero
        wr_word(5'h01, 16'h0000);
        rd_word(5'h00, 16'h5d00);
        rd_word(5'h01, 16'h0000);
        $display("test unmapped address done");
        // soft reset with a prompt and a slow core, strap changed meanwhile
        for (int k = 0; k < 2; k++) begin
            @(posedge clk);
            dly <= k ? 4'h8 : 4'h1;
            strap <= k[0];
            wr_word(5'h00, 16'hc400);
            check({15'h0, srst}, 16'h0001);
            rd_word(5'h00, 16'hd500);
            if (k == 1) begin
                wr_word(5'h00, 16'h0000);
                check({15'h0, srst}, 16'h0001);
                check({13'h0, loop, pd, iso}, 16'h0005);
            end
            wait_for(1'b0, 1'b0);
            @(negedge clk);
            rd_word(5'h00, k ? 16'h1900 : 16'h1100);
            check({13'h0, loop, pd, iso}, {13'h0, 1'b0, k[0], 1'b0});
        end
        $display("test soft reset done");
        reset_dut(1'b1);
        rd_word(5'h00, 16'h1900);
        check({15'h0, pd}, 16'h0001);
        $display("test strap at reset done");
        give_verdict();
    end
endmodule : tb_phy_basic_control_register

`default_nettype wire
